/* dcs_cmd_select.v */
// Drive command source, frequency source and serial link configuration block
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// - Codes 0-2 RTU 8 data 1 stop, parity none/odd/even.
// - Codes 3-5 RTU 8 data 2 stop, parity none/odd/even.
// - Codes 6-11 ASCII 7 data; 6-8 one stop, 9-11 two.
// - Codes 12-17 ASCII 8 data; 12-14 one stop, 15-17 two.
// - Station 1 to 247 accepted; 0 is broadcast.
// - Link timeout 0.1-100.0 s; 0.0 disables, default.
// - Action 0 alarms and coasts; 1 (default) keeps running.
// - Actions 2/3 stop; 2 under serial commands only, 3 always.
// - Write ack 0 (default) replies to writes; 1 suppresses.
// - Control mode 0 sensorless vector, 1 volts-per-hertz (default).
// - Command source 0 keypad (default), 1 terminals, 2 host.
// - Terminals give forward, reverse, forward jog, reverse jog.
// - Up/down trim adds onto any source except PID (5), top priority.
// - Trim mode 0 keeps trim over power loss, reapplies it.
// - Trim mode 1 trims while powered, drops it at power-down.
// - Trim mode 2 clears trim, ignores all up/down inputs.
// - Restoring defaults clears the trim.
// - Freq source 0-6: keypad, voltage, current, sum, multi-speed, PID, host.
// - Keypad source uses the keypad setpoint parameter.
// - Analog +100.0% is max frequency, -100.0% max reverse.
// - PID source sets operating frequency to PID output.
`include "dcs_defs.vh"
module dcs_cmd_select #(
  parameter TICK_CYCLES = `DCS_TICK_NS / `DCS_CLK_NS,
  parameter TRIM_STEP = 1
) (
  input wire MCLK_I, // 50 MHz core clock
  input wire RST_N_I, // Async reset, active low
  input wire [7:0] AVS_ADDRESS_I, // Byte address
  input wire AVS_READ_I, // Read request
  input wire AVS_WRITE_I, // Write request
  input wire [3:0] AVS_BYTEENABLE_I, // Byte lanes
  input wire [31:0] AVS_WRITEDATA_I, // Write data
  output wire [31:0] AVS_READDATA_O, // Read data
  output wire AVS_WAITREQUEST_O, // Stall
  input wire KEY_RUN_I, // Keypad run button
  input wire KEY_STOP_I, // Keypad stop button
  input wire KEY_UP_I, // Keypad increment
  input wire KEY_DOWN_I, // Keypad decrement
  input wire TERM_FWD_I, // Terminal forward run
  input wire TERM_REV_I, // Terminal reverse run
  input wire TERM_JOG_FWD_I, // Terminal forward jog
  input wire TERM_JOG_REV_I, // Terminal reverse jog
  input wire TERM_UP_I, // Terminal increment
  input wire TERM_DOWN_I, // Terminal decrement
  input wire POWER_DOWN_I, // Supply loss sense
  input wire HOST_RUN_I, // Host run level
  input wire HOST_REV_I, // Host reverse level
  input wire HOST_JOG_I, // Host jog level
  input wire FRAME_OK_I, // Valid frame pulse
  input wire [7:0] FRAME_ADDR_I, // Frame station address
  input wire FRAME_WR_I, // Frame is a write
  input wire signed [10:0] VOLT_PCT_I, // Voltage input, 0.1 %
  input wire signed [10:0] CURR_PCT_I, // Current input, 0.1 %
  input wire signed [17:0] MULTI_FREQ_I, // Multi-speed freq
  input wire signed [17:0] PID_FREQ_I, // PID freq
  input wire signed [17:0] HOST_FREQ_I, // Host freq
  input wire NV_LOAD_I, // Stored trim valid pulse
  input wire signed [17:0] NV_TRIM_I, // Stored trim value
  output reg NV_SAVE_O, // Store trim pulse
  output reg signed [17:0] NV_TRIM_O, // Trim to store
  output reg ASCII_MODE_O, // 1 ASCII, 0 RTU
  output reg DATA8_O, // 8 data bits
  output reg STOP2_O, // 2 stop bits
  output reg [1:0] PARITY_O, // 0 none 1 odd 2 even
  output reg FRAME_ACCEPT_O, // Frame for this station
  output reg REPLY_REQ_O, // Send a reply
  output reg VECTOR_MODE_O, // Sensorless vector selected
  output reg RUN_O, // Run command
  output reg REV_O, // Reverse direction
  output reg JOG_O, // Jog command
  output reg ALARM_O, // Link fault alarm
  output reg COAST_O, // Coast to stop
  output reg STOP_REQ_O, // Ramp stop request
  output reg signed [17:0] SETPOINT_O // Freq setpoint, 0.01 Hz
);
  // ----
  // Functions
  // ----
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[8*i +: 8] = wd[8*i +: 8];
        end
      end
    end
  endfunction

  function signed [17:0] pct_to_freq;
    input signed [11:0] p;
    input [15:0] m;
    reg signed [29:0] prod;
    reg signed [29:0] quot;
    begin
      prod = p * $signed({1'b0, m});
      quot = prod / `DCS_PCT_FULL;
      pct_to_freq = quot[17:0];
    end
  endfunction

  function signed [17:0] clamp;
    input signed [18:0] v;
    input [15:0] m;
    begin
      if (v > $signed({3'b000, m})) begin
        clamp = $signed({2'b00, m});
      end else if (v < -$signed({3'b000, m})) begin
        clamp = -$signed({2'b00, m});
      end else begin
        clamp = v[17:0];
      end
    end
  endfunction

  // ----
  // Pin synchronisers
  // ----
  localparam NPIN = 11;
  localparam P_RUN = 10, P_STOP = 9, P_KUP = 8, P_KDN = 7, P_FWD = 6, P_REV = 5;
  localparam P_JF = 4, P_JR = 3, P_TUP = 2, P_TDN = 1, P_PWR = 0;
  wire [NPIN-1:0] pins = {KEY_RUN_I, KEY_STOP_I, KEY_UP_I, KEY_DOWN_I, TERM_FWD_I,
    TERM_REV_I, TERM_JOG_FWD_I, TERM_JOG_REV_I, TERM_UP_I, TERM_DOWN_I, POWER_DOWN_I};
  reg [NPIN-1:0] sync1_reg;
  reg [NPIN-1:0] sync2_reg;
  reg [NPIN-1:0] prev_reg;
  wire [NPIN-1:0] rise = sync2_reg & ~prev_reg;
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync1_reg <= {NPIN{1'b0}};
      sync2_reg <= {NPIN{1'b0}};
      prev_reg <= {NPIN{1'b0}};
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ----
  // Avalon slave, one wait state
  // ----
  reg ack_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg [4:0] frame_reg;
  reg [9:0] tmo_reg;
  reg [1:0] action_reg;
  reg wack_reg;
  reg cmode_reg;
  reg [1:0] csrc_reg;
  reg [1:0] tmode_reg;
  reg [2:0] fsrc_reg;
  reg [15:0] keyfreq_reg;
  reg [15:0] maxfreq_reg;
  reg [7:0] station_reg;
  reg fault_reg;
  reg signed [17:0] trim_reg;
  wire req = AVS_READ_I | AVS_WRITE_I;
  wire wr_go = AVS_WRITE_I & ack_reg;
  wire [31:0] wd = AVS_WRITEDATA_I;
  assign AVS_WAITREQUEST_O = req & ~ack_reg;
  assign AVS_READDATA_O = rdata_reg;
  wire [31:0] ctrl_w = merge(32'h0, wd, AVS_BYTEENABLE_I);
  wire [31:0] keyfreq_w = merge({16'h0, keyfreq_reg}, wd, AVS_BYTEENABLE_I);
  wire restore = wr_go && AVS_ADDRESS_I == `DCS_OFS_CTRL && ctrl_w[`DCS_CTRL_RESTORE];
  wire clr_flt = wr_go && AVS_ADDRESS_I == `DCS_OFS_CTRL && ctrl_w[`DCS_CTRL_CLRFLT];

  always @* begin
    rdata_next = 32'h0;
    case (AVS_ADDRESS_I)
      `DCS_OFS_FRAME: rdata_next = {27'h0, frame_reg};
      `DCS_OFS_TMO: rdata_next = {22'h0, tmo_reg};
      `DCS_OFS_ACTION: rdata_next = {30'h0, action_reg};
      `DCS_OFS_WACK: rdata_next = {31'h0, wack_reg};
      `DCS_OFS_CMODE: rdata_next = {31'h0, cmode_reg};
      `DCS_OFS_CSRC: rdata_next = {30'h0, csrc_reg};
      `DCS_OFS_TRIMMODE: rdata_next = {30'h0, tmode_reg};
      `DCS_OFS_FSRC: rdata_next = {29'h0, fsrc_reg};
      `DCS_OFS_KEYFREQ: rdata_next = {16'h0, keyfreq_reg};
      `DCS_OFS_MAXFREQ: rdata_next = {16'h0, maxfreq_reg};
      `DCS_OFS_STATION: rdata_next = {24'h0, station_reg};
      `DCS_OFS_STATUS: rdata_next = {22'h0, RUN_O, REV_O, JOG_O, ALARM_O, STOP_REQ_O,
        PARITY_O, STOP2_O, DATA8_O, fault_reg};
      `DCS_OFS_TRIM: rdata_next = {{14{trim_reg[17]}}, trim_reg};
      `DCS_OFS_SETPT: rdata_next = {{14{SETPOINT_O[17]}}, SETPOINT_O};
      default: rdata_next = 32'h0;
    endcase
  end

  // Restore wins over a same-cycle write, it is the later intent
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
      frame_reg <= `DCS_RST_FRAME;
      tmo_reg <= `DCS_RST_TMO;
      action_reg <= `DCS_RST_ACTION;
      wack_reg <= `DCS_RST_WACK;
      cmode_reg <= `DCS_RST_CMODE;
      csrc_reg <= `DCS_RST_CSRC;
      tmode_reg <= `DCS_RST_TRIMMODE;
      fsrc_reg <= `DCS_RST_FSRC;
      keyfreq_reg <= `DCS_RST_KEYFREQ;
      maxfreq_reg <= `DCS_RST_MAXFREQ;
      station_reg <= `DCS_RST_STATION;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg) begin
        rdata_reg <= rdata_next;
      end
      if (restore) begin
        frame_reg <= `DCS_RST_FRAME;
        tmo_reg <= `DCS_RST_TMO;
        action_reg <= `DCS_RST_ACTION;
        wack_reg <= `DCS_RST_WACK;
        cmode_reg <= `DCS_RST_CMODE;
        csrc_reg <= `DCS_RST_CSRC;
        tmode_reg <= `DCS_RST_TRIMMODE;
        fsrc_reg <= `DCS_RST_FSRC;
        keyfreq_reg <= `DCS_RST_KEYFREQ;
        maxfreq_reg <= `DCS_RST_MAXFREQ;
        station_reg <= `DCS_RST_STATION;
      end else if (wr_go) begin
        // Out-of-range field values are dropped, old setting kept; bits above each field are not checked
        case (AVS_ADDRESS_I)
          `DCS_OFS_FRAME: if (ctrl_w[4:0] <= `DCS_FRAME_MAX) frame_reg <= ctrl_w[4:0];
          `DCS_OFS_TMO: if (ctrl_w[9:0] <= `DCS_TMO_MAX) tmo_reg <= ctrl_w[9:0];
          `DCS_OFS_ACTION: action_reg <= ctrl_w[1:0];
          `DCS_OFS_WACK: wack_reg <= ctrl_w[0];
          `DCS_OFS_CMODE: cmode_reg <= ctrl_w[0];
          `DCS_OFS_CSRC: if (ctrl_w[1:0] != 2'h3) csrc_reg <= ctrl_w[1:0];
          `DCS_OFS_TRIMMODE: if (ctrl_w[1:0] != 2'h3) tmode_reg <= ctrl_w[1:0];
          `DCS_OFS_FSRC: if (ctrl_w[2:0] != 3'h7) fsrc_reg <= ctrl_w[2:0];
          `DCS_OFS_KEYFREQ: keyfreq_reg <= keyfreq_w[15:0];
          `DCS_OFS_MAXFREQ: maxfreq_reg <= ctrl_w[15:0];
          `DCS_OFS_STATION: begin
            if (ctrl_w[7:0] != `DCS_BCAST && ctrl_w[7:0] <= `DCS_STATION_MAX) begin
              station_reg <= ctrl_w[7:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ----
  // Frame format decode
  // ----
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ASCII_MODE_O <= 1'b0;
      DATA8_O <= 1'b1;
      STOP2_O <= 1'b0;
      PARITY_O <= 2'h0;
      VECTOR_MODE_O <= 1'b0;
    end else begin
      VECTOR_MODE_O <= ~cmode_reg;
      if (frame_reg < 5'h06) begin
        ASCII_MODE_O <= 1'b0;
        DATA8_O <= 1'b1;
        STOP2_O <= frame_reg >= 5'h03;
        PARITY_O <= (frame_reg >= 5'h03) ? frame_reg[1:0] - 2'h3 : frame_reg[1:0];
      end else if (frame_reg < 5'h0c) begin
        ASCII_MODE_O <= 1'b1;
        DATA8_O <= 1'b0;
        STOP2_O <= frame_reg >= 5'h09;
        PARITY_O <= (frame_reg >= 5'h09) ? frame_reg[1:0] - 2'h1 : frame_reg[1:0] - 2'h2;
      end else begin
        ASCII_MODE_O <= 1'b1;
        DATA8_O <= 1'b1;
        STOP2_O <= frame_reg >= 5'h0f;
        PARITY_O <= (frame_reg >= 5'h0f) ? frame_reg[1:0] - 2'h3 : frame_reg[1:0];
      end
    end
  end

  // ----
  // Frame acceptance and link timeout
  // ----
  wire addr_hit = FRAME_ADDR_I == station_reg || FRAME_ADDR_I == `DCS_BCAST;
  wire accept = FRAME_OK_I & addr_hit;
  reg [31:0] tick_cnt_reg;
  reg [9:0] elapsed_reg;
  wire tick = tick_cnt_reg == TICK_CYCLES - 1;
  wire tmo_hit = tmo_reg != 10'h0 && elapsed_reg >= tmo_reg;
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      FRAME_ACCEPT_O <= 1'b0;
      REPLY_REQ_O <= 1'b0;
      tick_cnt_reg <= 32'h0;
      elapsed_reg <= 10'h0;
      fault_reg <= 1'b0;
    end else begin
      FRAME_ACCEPT_O <= accept;
      // No reply to broadcasts, none to writes when suppressed
      REPLY_REQ_O <= accept && FRAME_ADDR_I != `DCS_BCAST && !(FRAME_WR_I && wack_reg);
      if (accept) begin
        tick_cnt_reg <= 32'h0;
        elapsed_reg <= 10'h0;
      end else if (tick) begin
        tick_cnt_reg <= 32'h0;
        if (elapsed_reg != `DCS_TMO_MAX) elapsed_reg <= elapsed_reg + 10'h1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end
      // Set beats a same-cycle clear
      if (tmo_hit) begin
        fault_reg <= 1'b1;
      end else if (clr_flt) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // ----
  // Fault action and run command source
  // ----
  reg key_run_reg;
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ALARM_O <= 1'b0;
      COAST_O <= 1'b0;
      STOP_REQ_O <= 1'b0;
      key_run_reg <= 1'b0;
      RUN_O <= 1'b0;
      REV_O <= 1'b0;
      JOG_O <= 1'b0;
    end else begin
      ALARM_O <= fault_reg && action_reg == 2'h0;
      COAST_O <= fault_reg && action_reg == 2'h0;
      STOP_REQ_O <= fault_reg && (action_reg == 2'h3 ||
        (action_reg == 2'h2 && csrc_reg == 2'h2));
      if (rise[P_STOP] || csrc_reg != 2'h0) begin
        key_run_reg <= 1'b0;
      end else if (rise[P_RUN]) begin
        key_run_reg <= 1'b1;
      end
      case (csrc_reg)
        2'h0: begin
          RUN_O <= key_run_reg;
          REV_O <= 1'b0;
          JOG_O <= 1'b0;
        end
        2'h1: begin
          // Run levels win over jog levels; forward wins a tie
          RUN_O <= |sync2_reg[P_FWD:P_JR];
          REV_O <= sync2_reg[P_FWD] ? 1'b0 : sync2_reg[P_REV] ? 1'b1 :
            (sync2_reg[P_JR] & ~sync2_reg[P_JF]);
          JOG_O <= ~(sync2_reg[P_FWD] | sync2_reg[P_REV]) & (sync2_reg[P_JF] | sync2_reg[P_JR]);
        end
        2'h2: begin
          RUN_O <= HOST_RUN_I;
          REV_O <= HOST_REV_I;
          JOG_O <= HOST_JOG_I;
        end
        default: begin
          RUN_O <= 1'b0;
          REV_O <= 1'b0;
          JOG_O <= 1'b0;
        end
      endcase
    end
  end

  // ----
  // Up/down trim with retention
  // ----
  wire inc = rise[P_KUP] | rise[P_TUP];
  wire dec = rise[P_KDN] | rise[P_TDN];
  wire pwr_fall = rise[P_PWR];
  reg signed [18:0] trim_next;
  localparam signed [18:0] STEP = TRIM_STEP;
  always @* begin
    trim_next = {trim_reg[17], trim_reg};
    if (inc & ~dec) trim_next = trim_next + STEP;
    if (dec & ~inc) trim_next = trim_next - STEP;
  end
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      trim_reg <= 18'sh0;
      NV_SAVE_O <= 1'b0;
      NV_TRIM_O <= 18'sh0;
    end else begin
      NV_SAVE_O <= pwr_fall;
      NV_TRIM_O <= (tmode_reg == 2'h0) ? trim_reg : 18'sh0;
      if (restore || tmode_reg == 2'h2) begin
        trim_reg <= 18'sh0;
      end else if (pwr_fall && tmode_reg == 2'h1) begin
        trim_reg <= 18'sh0;
      end else if (NV_LOAD_I && tmode_reg == 2'h0) begin
        trim_reg <= NV_TRIM_I;
      end else begin
        trim_reg <= clamp(trim_next, maxfreq_reg);
      end
    end
  end

  // ----
  // Frequency source select and trim sum
  // ----
  reg signed [17:0] base;
  wire signed [11:0] sum_pct = {VOLT_PCT_I[10], VOLT_PCT_I} + {CURR_PCT_I[10], CURR_PCT_I};
  always @* begin
    case (fsrc_reg)
      3'h0: base = $signed({2'b00, keyfreq_reg});
      3'h1: base = pct_to_freq({VOLT_PCT_I[10], VOLT_PCT_I}, maxfreq_reg);
      3'h2: base = pct_to_freq({CURR_PCT_I[10], CURR_PCT_I}, maxfreq_reg);
      3'h3: base = pct_to_freq(sum_pct, maxfreq_reg);
      3'h4: base = MULTI_FREQ_I;
      3'h5: base = PID_FREQ_I;
      3'h6: base = HOST_FREQ_I;
      default: base = 18'sh0;
    endcase
  end
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SETPOINT_O <= 18'sh0;
    end else if (fsrc_reg == 3'h5) begin
      SETPOINT_O <= PID_FREQ_I;
    end else begin
      // Trim sits on top of every other source
      SETPOINT_O <= clamp({base[17], base} + {trim_reg[17], trim_reg}, maxfreq_reg);
    end
  end
endmodule

/* dcs_cmd_select_sva.sv */
// Concurrent checks on the drive command selector ports
`timescale 1ns/10ps
`include "dcs_defs.vh"
module dcs_cmd_select_chk (
  input logic MCLK_I, // clock
  input logic RST_N_I, // reset
  input logic [7:0] AVS_ADDRESS_I, // address
  input logic AVS_WRITE_I, // write
  input logic [31:0] AVS_WRITEDATA_I, // data
  input logic AVS_WAITREQUEST_O, // stall
  input logic TERM_FWD_I, // fwd
  input logic TERM_REV_I, // rev
  input logic HOST_RUN_I, // host run
  input logic HOST_JOG_I, // host jog
  input logic FRAME_OK_I, // frame
  input logic [7:0] FRAME_ADDR_I, // station
  input logic signed [17:0] PID_FREQ_I, // pid
  input logic FRAME_ACCEPT_O, // accept
  input logic REPLY_REQ_O, // reply
  input logic ASCII_MODE_O, // ascii
  input logic DATA8_O, // data8
  input logic STOP2_O, // stop2
  input logic [1:0] PARITY_O, // parity
  input logic VECTOR_MODE_O, // vector
  input logic RUN_O, // run
  input logic REV_O, // rev out
  input logic JOG_O, // jog out
  input logic signed [17:0] SETPOINT_O // setpoint
);
  logic [4:0] frame_q;
  logic [1:0] csrc_q;
  logic [2:0] fsrc_q;
  logic cmode_q;
  wire wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  wire [31:0] wd = AVS_WRITEDATA_I;
  wire ex_stop2 = (frame_q < 5'd6) ? (frame_q > 5'd2) : ((frame_q - 5'd6) % 5'd6 > 5'd2);
  wire [4:0] ex_par = frame_q % 5'd3;
  // ----
  // Shadow of the selectors
  // ----
  // Full-word writes only
  always @(posedge MCLK_I) begin
    if (!RST_N_I || (wr_ok && AVS_ADDRESS_I == `DCS_OFS_CTRL && wd[0])) begin
      {frame_q, csrc_q, fsrc_q, cmode_q} <= {`DCS_RST_FRAME, `DCS_RST_CSRC, `DCS_RST_FSRC, 1'b1};
    end else if (wr_ok) begin
      case (AVS_ADDRESS_I)
        `DCS_OFS_FRAME: if (wd <= 32'h11) frame_q <= wd[4:0];
        `DCS_OFS_CMODE: if (wd <= 32'h1) cmode_q <= wd[0];
        `DCS_OFS_CSRC: if (wd <= 32'h2) csrc_q <= wd[1:0];
        `DCS_OFS_FSRC: if (wd <= 32'h6) fsrc_q <= wd[2:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_frame_held;
    $stable(frame_q)[*3];
  endsequence
  sequence s_pid_held;
    (fsrc_q == 3'h5 && $stable(PID_FREQ_I))[*3];
  endsequence
  sequence s_host_held;
    (csrc_q == 2'h2 && !HOST_JOG_I && $stable(HOST_RUN_I))[*3];
  endsequence
  sequence s_term_fwd;
    (csrc_q == 2'h1 && TERM_FWD_I && !TERM_REV_I)[*6];
  endsequence
  a_broadcast_noreply: assert property (FRAME_OK_I && FRAME_ADDR_I == 8'h00 |=>
    FRAME_ACCEPT_O && !REPLY_REQ_O) else $error("broadcast not accepted silently");
  a_accept_cause: assert property (!FRAME_OK_I |=> !FRAME_ACCEPT_O)
    else $error("accept without frame");
  a_reply_accept: assert property (REPLY_REQ_O |-> FRAME_ACCEPT_O)
    else $error("reply without accepted frame");
  a_frame_kind: assert property (s_frame_held |->
    ASCII_MODE_O == (frame_q > 5'd5)) else $error("framing kind wrong");
  a_frame_bits: assert property (s_frame_held |->
    STOP2_O == ex_stop2 && PARITY_O == ex_par[1:0]) else $error("stop or parity wrong");
  a_rtu_eight: assert property (!ASCII_MODE_O |-> DATA8_O)
    else $error("rtu without eight data bits");
  a_vector_sel: assert property ($stable(cmode_q)[*3] |-> VECTOR_MODE_O == !cmode_q)
    else $error("control mode output wrong");
  a_pid_pass: assert property (s_pid_held |-> SETPOINT_O == PID_FREQ_I)
    else $error("pid setpoint wrong");
  a_host_run: assert property (s_host_held |-> RUN_O == HOST_RUN_I)
    else $error("host run not followed");
  a_term_fwd: assert property (s_term_fwd |-> RUN_O && !REV_O && !JOG_O)
    else $error("terminal forward not decoded");
endmodule
bind dcs_cmd_select dcs_cmd_select_chk i_chk (.*);

/* dcs_defs.vh */
// Register map, reset values and timing constants of the drive command selector
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH
// ----
// Register byte offsets
// ----
`define DCS_OFS_FRAME 8'h00
`define DCS_OFS_TMO 8'h04
`define DCS_OFS_ACTION 8'h08
`define DCS_OFS_WACK 8'h0c
`define DCS_OFS_CMODE 8'h10
`define DCS_OFS_CSRC 8'h14
`define DCS_OFS_TRIMMODE 8'h18
`define DCS_OFS_FSRC 8'h1c
`define DCS_OFS_KEYFREQ 8'h20
`define DCS_OFS_MAXFREQ 8'h24
`define DCS_OFS_STATION 8'h28
`define DCS_OFS_CTRL 8'h2c
`define DCS_OFS_STATUS 8'h30
`define DCS_OFS_TRIM 8'h34
`define DCS_OFS_SETPT 8'h38
// ----
// Reset values
// ----
`define DCS_RST_FRAME 5'h00
`define DCS_RST_TMO 10'h000
`define DCS_RST_ACTION 2'h1
`define DCS_RST_WACK 1'h0
`define DCS_RST_CMODE 1'h1
`define DCS_RST_CSRC 2'h0
`define DCS_RST_TRIMMODE 2'h0
`define DCS_RST_FSRC 3'h0
`define DCS_RST_KEYFREQ 16'h1388
`define DCS_RST_MAXFREQ 16'h1388
`define DCS_RST_STATION 8'h01
// ----
// Field positions and limits
// ----
`define DCS_CTRL_RESTORE 0
`define DCS_CTRL_CLRFLT 1
`define DCS_FRAME_MAX 5'h11
`define DCS_TMO_MAX 10'h3e8
`define DCS_STATION_MAX 8'hf7
`define DCS_BCAST 8'h00
`define DCS_PCT_FULL 30'sh3e8
// ----
// Timing
// ----
`define DCS_CLK_NS 20
`define DCS_TICK_NS 100000000
`endif

/* dcs_host_model.sv */
// Behavioural serial host driving frame events and command levels
`timescale 1ns/10ps
module dcs_host_model (
  input logic clk_i, // core clock
  output logic frame_ok_o, // valid frame pulse
  output logic [7:0] frame_addr_o, // target station
  output logic frame_wr_o, // frame is a write
  output logic run_o, // host run level
  output logic rev_o, // host reverse level
  output logic jog_o // host jog level
);
  initial begin
    frame_ok_o = 1'b0;
    frame_addr_o = 8'h00;
    frame_wr_o = 1'b0;
    {run_o, rev_o, jog_o} = 3'h0;
  end
  // Call just after a rising edge; the pulse lasts one cycle
  task send(input logic [7:0] a, input logic w);
    begin
      frame_ok_o <= 1'b1;
      frame_addr_o <= a;
      frame_wr_o <= w;
      @(posedge clk_i);
      // Qualifiers are not held after the pulse, so show junk
      frame_ok_o <= 1'b0;
      frame_addr_o <= ~a;
      frame_wr_o <= ~w;
    end
  endtask
  task levels(input logic r, input logic v, input logic j);
    begin
      run_o <= r;
      rev_o <= v;
      jog_o <= j;
    end
  endtask
endmodule

/* tb.sv */
// Self-checking bench for the drive command selector
`timescale 1ns/10ps
`include "dcs_defs.vh"
module tb;
  logic MCLK_I = 1'b0, RST_N_I = 1'b0, AVS_READ_I = 1'b0, AVS_WRITE_I = 1'b0;
  logic [7:0] AVS_ADDRESS_I = 8'h00;
  logic [31:0] AVS_WRITEDATA_I = 32'h0, rdv;
  wire [3:0] AVS_BYTEENABLE_I = 4'hf;
  wire [31:0] AVS_READDATA_O;
  logic KEY_RUN_I = 1'b0, KEY_STOP_I = 1'b0, KEY_UP_I = 1'b0, KEY_DOWN_I = 1'b0;
  logic TERM_FWD_I = 1'b0, TERM_REV_I = 1'b0, TERM_JOG_FWD_I = 1'b0, TERM_JOG_REV_I = 1'b0;
  logic TERM_UP_I = 1'b0, TERM_DOWN_I = 1'b0, POWER_DOWN_I = 1'b0, NV_LOAD_I = 1'b0;
  logic signed [10:0] VOLT_PCT_I = 11'sh0, CURR_PCT_I = 11'sh0;
  logic signed [17:0] MULTI_FREQ_I = 18'sh0, PID_FREQ_I = 18'sh0, HOST_FREQ_I = 18'sh0;
  logic signed [17:0] NV_TRIM_I = 18'sh0;
  wire FRAME_OK_I, FRAME_WR_I, HOST_RUN_I, HOST_REV_I, HOST_JOG_I, AVS_WAITREQUEST_O;
  wire [7:0] FRAME_ADDR_I;
  wire NV_SAVE_O, ASCII_MODE_O, DATA8_O, STOP2_O, FRAME_ACCEPT_O, REPLY_REQ_O, VECTOR_MODE_O;
  wire RUN_O, REV_O, JOG_O, ALARM_O, COAST_O, STOP_REQ_O;
  wire [1:0] PARITY_O;
  wire signed [17:0] NV_TRIM_O, SETPOINT_O;
  wire [2:0] act = {ALARM_O, COAST_O, STOP_REQ_O};
  wire [4:0] fmt = {ASCII_MODE_O, DATA8_O, STOP2_O, PARITY_O};
  int n_mismatch = 0, check_count = 0, cyc = 0, i;
  // Setpoints for sources 1..6 at full scale 5000
  int sexp [7] = '{0, 1000, 1500, 2500, 777, 40000, 321};
  dcs_cmd_select #(.TICK_CYCLES(10)) i_dcs_cmd_select (.*);
  dcs_host_model i_dcs_host_model (.clk_i(MCLK_I), .frame_ok_o(FRAME_OK_I),
    .frame_addr_o(FRAME_ADDR_I), .frame_wr_o(FRAME_WR_I), .run_o(HOST_RUN_I),
    .rev_o(HOST_REV_I), .jog_o(HOST_JOG_I));
  always #10 MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  end
  // ----
  // Bus and check tasks
  // ----
  task w(input int n);
    repeat (n) @(posedge MCLK_I);
  endtask
  task acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    begin
      AVS_ADDRESS_I <= a;
      AVS_WRITEDATA_I <= d;
      AVS_WRITE_I <= wr;
      AVS_READ_I <= !wr;
      @(posedge MCLK_I);
      while (AVS_WAITREQUEST_O !== 1'b0) @(posedge MCLK_I);
      rdv = AVS_READDATA_O;
      AVS_WRITE_I <= 1'b0;
      AVS_READ_I <= 1'b0;
      repeat (2) @(posedge MCLK_I);
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      check_count++;
      if (g !== e) begin
        n_mismatch++;
        $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    begin
      acc(1'b0, a, 32'h0);
      chk(rdv, e);
    end
  endtask
  task frm(input logic [7:0] a, input logic f, input logic [1:0] e);
    begin
      i_dcs_host_model.send(a, f);
      @(posedge MCLK_I);
      chk({FRAME_ACCEPT_O, REPLY_REQ_O}, e);
    end
  endtask
  task tap(input int k);
    begin
      {KEY_RUN_I, KEY_STOP_I, KEY_UP_I, TERM_UP_I, TERM_DOWN_I, POWER_DOWN_I} <= 6'h01 << k;
      w(6);
      {KEY_RUN_I, KEY_STOP_I, KEY_UP_I, TERM_UP_I, TERM_DOWN_I, POWER_DOWN_I} <= 6'h0;
      w(6);
    end
  endtask
  function logic [4:0] fexp(input int c);
    fexp = {c > 5, c < 6 || c > 11, (c < 6) ? c > 2 : (c - 6) % 6 > 2, 2'(c % 3)};
  endfunction
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    w(10);
    RST_N_I <= 1'b1;
    w(2);
    rd(`DCS_OFS_FRAME, 0);
    rd(`DCS_OFS_TMO, 0);
    rd(`DCS_OFS_ACTION, 1);
    rd(`DCS_OFS_WACK, 0);
    rd(`DCS_OFS_CSRC, 0);
    rd(`DCS_OFS_FSRC, 0);
    chk(VECTOR_MODE_O, 0);
    chk(SETPOINT_O, 5000);
    acc(1'b1, 8'h40, 32'h5);
    rd(8'h40, 0);
    for (i = 0; i < 19; i++) begin
      wr(`DCS_OFS_FRAME, i);
      w(3);
      chk(fmt, fexp(i > 17 ? 17 : i));
    end
    wr(`DCS_OFS_STATION, 5);
    wr(`DCS_OFS_STATION, 0);
    wr(`DCS_OFS_STATION, 248);
    rd(`DCS_OFS_STATION, 5);
    frm(8'h05, 0, 2'b11);
    frm(8'h00, 1, 2'b10);
    frm(8'h06, 0, 2'b00);
    frm(8'h05, 1, 2'b11);
    wr(`DCS_OFS_WACK, 1);
    frm(8'h05, 1, 2'b10);
    frm(8'h05, 0, 2'b11);
    wr(`DCS_OFS_STATION, 247);
    frm(8'hf7, 0, 2'b11);
    wr(`DCS_OFS_TMO, 1001);
    rd(`DCS_OFS_TMO, 0);
    wr(`DCS_OFS_TMO, 1);
    wr(`DCS_OFS_ACTION, 0);
    w(30);
    chk(act, 3'b110);
    wr(`DCS_OFS_ACTION, 1);
    chk(act, 3'b000);
    wr(`DCS_OFS_ACTION, 3);
    chk(act, 3'b001);
    wr(`DCS_OFS_ACTION, 2);
    chk(act, 3'b000);
    wr(`DCS_OFS_CSRC, 2);
    chk(act, 3'b001);
    wr(`DCS_OFS_TMO, 3);
    i_dcs_host_model.send(8'hf7, 0);
    wr(`DCS_OFS_CTRL, 2);
    for (i = 0; i < 6; i++) begin
      i_dcs_host_model.send(8'hf7, 0);
      w(8);
    end
    acc(1'b0, `DCS_OFS_STATUS, 0);
    chk(rdv[0], 0);
    w(40);
    acc(1'b0, `DCS_OFS_STATUS, 0);
    chk(rdv[0], 1);
    wr(`DCS_OFS_TMO, 0);
    wr(`DCS_OFS_CTRL, 2);
    w(40);
    acc(1'b0, `DCS_OFS_STATUS, 0);
    chk(rdv[0], 0);
    wr(`DCS_OFS_CMODE, 0);
    w(3);
    chk(VECTOR_MODE_O, 1);
    i_dcs_host_model.levels(1, 1, 0);
    w(3);
    chk({RUN_O, REV_O}, 2'b11);
    i_dcs_host_model.levels(0, 0, 0);
    w(3);
    chk(RUN_O, 0);
    wr(`DCS_OFS_CSRC, 3);
    rd(`DCS_OFS_CSRC, 2);
    wr(`DCS_OFS_CSRC, 1);
    for (i = 0; i < 5; i++) begin
      {TERM_FWD_I, TERM_REV_I, TERM_JOG_FWD_I, TERM_JOG_REV_I} <= 4'b1000 >> i;
      w(8);
      chk({RUN_O, REV_O, JOG_O}, {i < 4, i == 1 || i == 3, i == 2 || i == 3});
    end
    wr(`DCS_OFS_CSRC, 0);
    tap(5);
    chk(RUN_O, 1);
    tap(4);
    chk(RUN_O, 0);
    {VOLT_PCT_I, CURR_PCT_I} <= {11'sd200, 11'sd300};
    {MULTI_FREQ_I, PID_FREQ_I, HOST_FREQ_I} <= {18'sd777, 18'sd40000, 18'sd321};
    for (i = 1; i < 7; i++) begin
      wr(`DCS_OFS_FSRC, i);
      w(3);
      chk(SETPOINT_O, sexp[i]);
    end
    VOLT_PCT_I <= -11'sd1000;
    wr(`DCS_OFS_FSRC, 1);
    w(3);
    chk(SETPOINT_O, -32'sd5000);
    wr(`DCS_OFS_FSRC, 0);
    wr(`DCS_OFS_KEYFREQ, 1234);
    for (i = 0; i < 3; i++) tap(3);
    tap(1);
    chk(SETPOINT_O, 1236);
    rd(`DCS_OFS_TRIM, 2);
    wr(`DCS_OFS_FSRC, 4);
    w(3);
    chk(SETPOINT_O, 779);
    wr(`DCS_OFS_FSRC, 0);
    tap(0);
    chk(NV_TRIM_O, 2);
    NV_TRIM_I <= 18'sd7;
    NV_LOAD_I <= 1'b1;
    w(1);
    NV_LOAD_I <= 1'b0;
    w(3);
    chk(SETPOINT_O, 1241);
    wr(`DCS_OFS_TRIMMODE, 1);
    tap(0);
    rd(`DCS_OFS_TRIM, 0);
    tap(3);
    rd(`DCS_OFS_TRIM, 1);
    wr(`DCS_OFS_TRIMMODE, 2);
    tap(3);
    tap(2);
    rd(`DCS_OFS_TRIM, 0);
    chk(SETPOINT_O, 1234);
    wr(`DCS_OFS_TRIMMODE, 0);
    tap(3);
    wr(`DCS_OFS_CTRL, 1);
    rd(`DCS_OFS_TRIM, 0);
    rd(`DCS_OFS_KEYFREQ, 16'h1388);
    complete_run;
  end
endmodule
